// file: rtl/uart_pkg.sv
/*
  constants shared by the serial transceiver data path, its checker and its bench:
  bus addresses, register field positions, reset values and bit timing.
  assumes a single 10 MHz clock and a synchronous active-high reset.
*/
package uart_pkg;
  // register addresses on the three address pins
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_CONFIG = 3'h1;
  localparam logic [2:0] ADDR_BAUD = 3'h2;
  localparam logic [2:0] ADDR_MODEM_CTRL = 3'h3;
  localparam logic [2:0] ADDR_STATUS = 3'h4;
  localparam logic [2:0] ADDR_MODEM_STAT = 3'h5;
  // uart_config_reg fields
  localparam int CFG_LEN_LO = 0;
  localparam int CFG_LEN_HI = 1;
  localparam int CFG_TWO_STOP = 2;
  localparam int CFG_RX_PAR_EN = 3;
  localparam int CFG_TX_PAR_EN = 4;
  localparam int CFG_RX_PAR_ODD = 5;
  localparam logic [5:0] CFG_RESET = 6'h03;
  // modem_control_reg fields
  localparam int MCR_RTS = 0;
  localparam int MCR_DTR = 1;
  localparam int MCR_GLOBAL_IRQ = 2;
  localparam int MCR_MODEM_IRQ = 3;
  localparam int MCR_RX_EN = 4;
  localparam int MCR_TX_PAR_ODD = 5;
  localparam logic [5:0] MCR_RESET = 6'h10;
  // uart_status_reg fields
  localparam int ST_PARITY = 0;
  localparam int ST_FRAMING = 1;
  localparam int ST_OVERRUN = 2;
  localparam int ST_BREAK = 3;
  localparam int ST_MODEM = 4;
  localparam int ST_TX_COMPLETE = 5;
  localparam int ST_TX_EMPTY = 6;
  localparam int ST_RX_READY = 7;
  localparam logic [7:0] STATUS_RESET = 8'h60;
  // status bits whose rising edge feeds the status interrupt path
  localparam logic [7:0] STATUS_IRQ_BITS = 8'h2f;
  // modem_status_reg fields
  localparam int MSR_CTS = 0;
  localparam int MSR_DSR = 1;
  // bit timing: the bit period is OVERSAMPLE clocks per divisor step
  localparam int OVERSAMPLE = 16;
  localparam int BIT_CNT_W = 13;
  localparam logic [7:0] BAUD_RESET = 8'h00;
  localparam int MIN_DATA_BITS = 5;
endpackage

// file: rtl/word_link_if.sv
/*
  valid/ready word link between the receiver and its holding buffer.
  assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface word_link_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface // word_link_if

// file: rtl/word_buffer.sv
/*
  small first-in first-out word buffer, flip-flop storage.
  assumes one clock, synchronous active-high reset.
*/
`timescale 1ns/10ps
module word_buffer #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic ref_clk,
  input wire logic srst,
  word_link_if.snk in_side,
  word_link_if.src out_side
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_side.ready = (count_r != FULL_COUNT);
  assign out_side.valid = (count_r != '0);
  assign out_side.data = mem_r[rd_ptr_r];
  assign push = in_side.valid & in_side.ready;
  assign pop = out_side.valid & out_side.ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_side.data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= next_ptr(wr_ptr_r);
      end
      if (pop) begin
        rd_ptr_r <= next_ptr(rd_ptr_r);
      end
      // simultaneous push and pop leave the count unchanged
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule // word_buffer

// file: rtl/uart_buffers_and_interrupts.sv
/*
  serial transceiver data path: receiver into a double-buffered holding
  register, transmit holding and shift registers, modem inputs, status
  and interrupt logic behind a chip-select/read/write strobe bus.
  assumes all pins synchronous to ref_clk, strobes held several clocks.
*/
`timescale 1ns/10ps
module uart_buffers_and_interrupts #(
  parameter int RX_BUF_DEPTH = 2
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic serial_in,
  output logic serial_out,
  input wire logic cts_n,
  input wire logic dsr_n,
  output logic rts_n,
  output logic dtr_n,
  output logic rx_data_ready,
  output logic tx_holding_empty,
  output logic irq_out
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_START = 3'b001,
    S_DATA = 3'b010,
    S_PARITY = 3'b011,
    S_STOP = 3'b100
  } line_state_e;

  localparam int BIT_CNT_W = uart_pkg::BIT_CNT_W;

  logic [5:0] uart_config_reg;
  logic [7:0] baud_select_reg;
  logic [5:0] modem_control_reg;
  logic [7:0] uart_status_reg;
  logic [7:0] rx_holding_reg;
  logic [7:0] tx_holding_reg;
  logic [7:0] tx_shift_reg;
  logic [7:0] rx_shift_r;
  logic rbr_full_r;
  logic tbr_full_r;
  logic rd_q_r;
  logic wr_q_r;
  logic [2:0] rd_addr_r;
  logic [7:0] snap_r;
  logic [7:0] pend_r;
  logic [7:0] status_prev_r;
  logic usr_irq_r;
  logic modem_irq_r;
  logic [1:0] modem_prev_r;
  line_state_e tx_state_r;
  line_state_e rx_state_r;
  logic [BIT_CNT_W-1:0] tx_cnt_r;
  logic [BIT_CNT_W-1:0] rx_cnt_r;
  logic [2:0] tx_bit_r;
  logic [2:0] rx_bit_r;
  logic tx_stop_left_r;
  logic tx_par_r;
  logic rx_par_bit_r;
  logic rx_done_r;
  logic rx_fe_r;
  logic rx_pe_r;
  logic rx_brk_r;
  logic serial_out_r;
  logic [7:0] data_out_r;
  logic data_oe_r;

  logic rd_act;
  logic wr_act;
  logic rd_end;
  logic wr_start;
  logic status_rd;
  logic modem_rd;
  logic status_rd_end;
  logic modem_rd_end;
  logic [2:0] last_bit;
  logic [BIT_CNT_W-1:0] bit_cycles;
  logic tx_load;
  logic tx_done;
  logic [7:0] ev;
  logic [1:0] modem_now;

  word_link_if #(.W(8)) rx_push ();
  word_link_if #(.W(8)) rx_pop ();

  // keeps only the configured number of data bits
  function automatic logic [7:0] len_mask(input logic [7:0] d, input logic [1:0] len);
    logic [7:0] m;
    m = 8'hff >> (2'h3 - len);
    len_mask = d & m;
  endfunction

  assign rd_act = ~cs_n & ~rd_n;
  assign wr_act = ~cs_n & ~wr_n;
  assign rd_end = rd_q_r & ~rd_act;
  assign wr_start = wr_act & ~wr_q_r;
  assign status_rd = rd_act & (addr == uart_pkg::ADDR_STATUS);
  assign modem_rd = rd_act & (addr == uart_pkg::ADDR_MODEM_STAT);
  assign status_rd_end = rd_end & (rd_addr_r == uart_pkg::ADDR_STATUS);
  assign modem_rd_end = rd_end & (rd_addr_r == uart_pkg::ADDR_MODEM_STAT);
  assign last_bit = 3'(uart_pkg::MIN_DATA_BITS - 1) + {1'b0, uart_config_reg[1:0]};
  assign bit_cycles = BIT_CNT_W'(uart_pkg::OVERSAMPLE)
                      * ({5'h00, baud_select_reg} + 13'h0001);
  assign modem_now = {~dsr_n, ~cts_n};

  // bus strobes, write side registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rd_q_r <= 1'b0;
      wr_q_r <= 1'b0;
      rd_addr_r <= 3'h0;
      uart_config_reg <= uart_pkg::CFG_RESET;
      baud_select_reg <= uart_pkg::BAUD_RESET;
      modem_control_reg <= uart_pkg::MCR_RESET;
    end else begin
      rd_q_r <= rd_act;
      wr_q_r <= wr_act;
      if (rd_act && !rd_q_r) begin
        rd_addr_r <= addr;
      end
      if (wr_start) begin
        case (addr)
          uart_pkg::ADDR_CONFIG: uart_config_reg <= data_in[5:0];
          uart_pkg::ADDR_BAUD: baud_select_reg <= data_in;
          uart_pkg::ADDR_MODEM_CTRL: modem_control_reg <= data_in[5:0];
          default: ;
        endcase
      end
    end
  end

  // read data, reloaded every cycle from the addressed register; config, baud and spare addresses read as zero
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      data_out_r <= 8'h00;
      data_oe_r <= 1'b0;
    end else begin
      data_oe_r <= rd_act;
      case (addr)
        uart_pkg::ADDR_DATA: data_out_r <= rx_holding_reg;
        uart_pkg::ADDR_MODEM_CTRL: data_out_r <= {2'h0, modem_control_reg};
        uart_pkg::ADDR_STATUS: data_out_r <= uart_status_reg;
        uart_pkg::ADDR_MODEM_STAT: data_out_r <= {6'h00, modem_now};
        default: data_out_r <= 8'h00;
      endcase
    end
  end

  // transmit holding register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_holding_reg <= 8'h00;
      tbr_full_r <= 1'b0;
    end else if (wr_start && addr == uart_pkg::ADDR_DATA) begin
      tx_holding_reg <= data_in;
      tbr_full_r <= 1'b1;
    end else if (tx_load) begin
      tbr_full_r <= 1'b0;
    end
  end

  // a character only starts from idle with clear-to-send asserted
  assign tx_load = (tx_state_r == S_IDLE) & tbr_full_r & ~cts_n;
  assign tx_done = (tx_state_r == S_STOP) & (tx_cnt_r == '0) & ~tx_stop_left_r;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_state_r <= S_IDLE;
      tx_cnt_r <= '0;
      tx_bit_r <= 3'h0;
      tx_shift_reg <= 8'h00;
      tx_stop_left_r <= 1'b0;
      tx_par_r <= 1'b0;
    end else begin
      tx_cnt_r <= (tx_cnt_r == '0) ? bit_cycles - 1'b1 : tx_cnt_r - 1'b1;
      case (tx_state_r)
        S_IDLE: begin
          tx_cnt_r <= bit_cycles - 1'b1;
          if (tx_load) begin
            tx_shift_reg <= len_mask(tx_holding_reg, uart_config_reg[1:0]);
            tx_par_r <= ^len_mask(tx_holding_reg, uart_config_reg[1:0])
                        ^ modem_control_reg[uart_pkg::MCR_TX_PAR_ODD];
            tx_bit_r <= 3'h0;
            tx_state_r <= S_START;
          end
        end
        S_START: begin
          if (tx_cnt_r == '0) begin
            tx_state_r <= S_DATA;
          end
        end
        S_DATA: begin
          if (tx_cnt_r == '0) begin
            tx_shift_reg <= tx_shift_reg >> 1;
            tx_bit_r <= tx_bit_r + 3'h1;
            if (tx_bit_r == last_bit) begin
              tx_stop_left_r <= uart_config_reg[uart_pkg::CFG_TWO_STOP];
              tx_state_r <= uart_config_reg[uart_pkg::CFG_TX_PAR_EN] ? S_PARITY : S_STOP;
            end
          end
        end
        S_PARITY: begin
          if (tx_cnt_r == '0) begin
            tx_state_r <= S_STOP;
          end
        end
        S_STOP: begin
          if (tx_cnt_r == '0) begin
            tx_stop_left_r <= 1'b0;
            // a deasserted clear-to-send only stops the next start
            if (!tx_stop_left_r) begin
              tx_state_r <= S_IDLE;
            end
          end
        end
        default: tx_state_r <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      serial_out_r <= 1'b1;
    end else begin
      case (tx_state_r)
        S_START: serial_out_r <= 1'b0;
        S_DATA: serial_out_r <= tx_shift_reg[0];
        S_PARITY: serial_out_r <= tx_par_r;
        default: serial_out_r <= 1'b1;
      endcase
    end
  end

  // receiver: the bit counter restarts from each start edge
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rx_state_r <= S_IDLE;
      rx_cnt_r <= '0;
      rx_bit_r <= 3'h0;
      rx_shift_r <= 8'h00;
      rx_par_bit_r <= 1'b0;
      rx_done_r <= 1'b0;
      rx_fe_r <= 1'b0;
      rx_pe_r <= 1'b0;
      rx_brk_r <= 1'b0;
    end else begin
      rx_done_r <= 1'b0;
      rx_cnt_r <= (rx_cnt_r == '0) ? bit_cycles - 1'b1 : rx_cnt_r - 1'b1;
      case (rx_state_r)
        S_IDLE: begin
          rx_cnt_r <= (bit_cycles >> 1) - 1'b1;
          if (modem_control_reg[uart_pkg::MCR_RX_EN] && !serial_in) begin
            rx_state_r <= S_START;
          end
        end
        S_START: begin
          if (rx_cnt_r == '0) begin
            rx_shift_r <= 8'h00;
            rx_bit_r <= 3'h0;
            // a glitch shorter than half a bit is not a start
            rx_state_r <= serial_in ? S_IDLE : S_DATA;
          end
        end
        S_DATA: begin
          if (rx_cnt_r == '0) begin
            rx_shift_r[rx_bit_r] <= serial_in;
            rx_bit_r <= rx_bit_r + 3'h1;
            if (rx_bit_r == last_bit) begin
              rx_state_r <= uart_config_reg[uart_pkg::CFG_RX_PAR_EN] ? S_PARITY : S_STOP;
            end
          end
        end
        S_PARITY: begin
          if (rx_cnt_r == '0) begin
            rx_par_bit_r <= serial_in;
            rx_state_r <= S_STOP;
          end
        end
        S_STOP: begin
          if (rx_cnt_r == '0) begin
            rx_done_r <= 1'b1;
            rx_fe_r <= ~serial_in;
            rx_pe_r <= uart_config_reg[uart_pkg::CFG_RX_PAR_EN]
                       & (^rx_shift_r ^ rx_par_bit_r
                          ^ uart_config_reg[uart_pkg::CFG_RX_PAR_ODD]);
            rx_brk_r <= ~serial_in & (rx_shift_r == 8'h00)
                        & ~(uart_config_reg[uart_pkg::CFG_RX_PAR_EN] & rx_par_bit_r);
            rx_state_r <= S_IDLE;
          end
        end
        default: rx_state_r <= S_IDLE;
      endcase
    end
  end

  // the buffer lets a word wait while the holding register is occupied
  assign rx_push.valid = rx_done_r;
  assign rx_push.data = len_mask(rx_shift_r, uart_config_reg[1:0]);
  assign rx_pop.ready = ~rbr_full_r;

  word_buffer #(.W(8), .DEPTH(RX_BUF_DEPTH)) rx_buf (
    .ref_clk(ref_clk),
    .srst(srst),
    .in_side(rx_push.snk),
    .out_side(rx_pop.src)
  );

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rx_holding_reg <= 8'h00;
      rbr_full_r <= 1'b0;
    end else if (rx_pop.valid && rx_pop.ready) begin
      rx_holding_reg <= rx_pop.data;
      rbr_full_r <= 1'b1;
    end else if (rd_end && rd_addr_r == uart_pkg::ADDR_DATA) begin
      rbr_full_r <= 1'b0;
    end
  end

  // one-cycle status events
  always_comb begin
    ev = 8'h00;
    ev[uart_pkg::ST_PARITY] = rx_done_r & rx_pe_r;
    ev[uart_pkg::ST_FRAMING] = rx_done_r & rx_fe_r;
    ev[uart_pkg::ST_OVERRUN] = rx_done_r & (rbr_full_r | rx_pop.valid);
    ev[uart_pkg::ST_BREAK] = rx_done_r & rx_brk_r;
    ev[uart_pkg::ST_MODEM] = (modem_now != modem_prev_r);
    ev[uart_pkg::ST_TX_COMPLETE] = tx_done & ~tbr_full_r;
    ev[uart_pkg::ST_TX_EMPTY] = tx_load;
    ev[uart_pkg::ST_RX_READY] = rx_pop.valid & rx_pop.ready;
  end

  // status register with read-time inhibit and trailing-edge update
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      uart_status_reg <= uart_pkg::STATUS_RESET;
      snap_r <= 8'h00;
      pend_r <= 8'h00;
      // start from the live pins so no false change follows reset
      modem_prev_r <= modem_now;
    end else begin
      modem_prev_r <= modem_now;
      if ((status_rd || modem_rd) && !rd_q_r) begin
        snap_r <= uart_status_reg;
      end
      if (status_rd || modem_rd) begin
        pend_r <= pend_r | ev;
      end else if (status_rd_end) begin
        // an event in the trailing cycle itself must not be lost
        uart_status_reg <= (pend_r & ~snap_r) | ev;
        pend_r <= 8'h00;
      end else if (modem_rd_end) begin
        uart_status_reg <= (uart_status_reg & ~(pend_r & snap_r))
                           | (pend_r & ~snap_r) | ev;
        pend_r <= 8'h00;
      end else begin
        uart_status_reg <= uart_status_reg | ev;
      end
    end
  end

  // interrupt edge detectors; a new edge wins over the clearing read
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      status_prev_r <= 8'h00;
      usr_irq_r <= 1'b0;
      modem_irq_r <= 1'b0;
    end else begin
      status_prev_r <= uart_status_reg;
      // ready and empty bits are masked out of this path
      if (|(uart_status_reg & ~status_prev_r & uart_pkg::STATUS_IRQ_BITS)) begin
        usr_irq_r <= 1'b1;
      end else if (status_rd_end) begin
        usr_irq_r <= 1'b0;
      end
      if (ev[uart_pkg::ST_MODEM]) begin
        modem_irq_r <= 1'b1;
      end else if (modem_rd_end) begin
        modem_irq_r <= 1'b0;
      end
    end
  end

  assign irq_out = modem_control_reg[uart_pkg::MCR_GLOBAL_IRQ]
                   & (usr_irq_r
                      | (modem_irq_r & modem_control_reg[uart_pkg::MCR_MODEM_IRQ]));
  assign rx_data_ready = rbr_full_r;
  assign tx_holding_empty = ~tbr_full_r;
  assign rts_n = ~modem_control_reg[uart_pkg::MCR_RTS];
  assign dtr_n = ~modem_control_reg[uart_pkg::MCR_DTR];
  assign serial_out = serial_out_r;
  assign data_out = data_out_r;
  assign data_oe = data_oe_r;
endmodule // uart_buffers_and_interrupts

// file: dv/uart_chk.sv
/*
  pin-level checker for the serial transceiver top module.
  assumes one clock, synchronous active-high reset; bound below.
*/
`timescale 1ns/10ps
module uart_chk #(
  parameter int RX_BUF_DEPTH = 2
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic rts_n,
  input wire logic dtr_n,
  input wire logic rx_data_ready,
  input wire logic tx_holding_empty,
  input wire logic irq_out
);
  default clocking cb @(posedge ref_clk);
  endclocking
  sequence rd_s(a);
    !cs_n && !rd_n && addr == a;
  endsequence
  // only the first strobe cycle counts as the write
  sequence wr_first_s(a);
    !cs_n && !wr_n && addr == a && ($past(cs_n) || $past(wr_n));
  endsequence
  reset_vals_a: assert property (
    srst |=> serial_out && tx_holding_empty && !rx_data_ready && !irq_out && !data_oe)
    else $error("pins wrong after reset");
  oe_on_a: assert property (disable iff (srst) !cs_n && !rd_n |=> data_oe)
    else $error("bus not driven during read");
  oe_off_a: assert property (disable iff (srst) cs_n || rd_n |=> !data_oe)
    else $error("bus driven after read");
  msr_read_a: assert property (
    disable iff (srst) rd_s(uart_pkg::ADDR_MODEM_STAT) [*2]
    |=> data_out == {6'h00, ~$past(dsr_n), ~$past(cts_n)})
    else $error("modem status not inverted pins");
  spare_read_a: assert property (disable iff (srst)
    !cs_n && !rd_n && addr > uart_pkg::ADDR_MODEM_STAT |=> data_out == 8'h00)
    else $error("unused address reads nonzero");
  wr_full_a: assert property (
    disable iff (srst) wr_first_s(uart_pkg::ADDR_DATA) |-> ##[1:2] !tx_holding_empty)
    else $error("empty pin ignores data write");
  mask_off_a: assert property (
    disable iff (srst) wr_first_s(uart_pkg::ADDR_MODEM_CTRL)
    ##0 !data_in[uart_pkg::MCR_GLOBAL_IRQ] |-> ##2 !irq_out)
    else $error("irq high with global mask off");
  // shortest bit is 16 clocks, so eight quiet cycles after any edge is safe
  bit_hold_a: assert property (disable iff (srst)
    $changed(serial_out) |=> $stable(serial_out) [*8])
    else $error("serial bit too short");
endmodule // uart_chk
bind uart_buffers_and_interrupts uart_chk #(.RX_BUF_DEPTH(RX_BUF_DEPTH)) u_chk (
  .ref_clk(ref_clk), .srst(srst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
  .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
  .serial_in(serial_in), .serial_out(serial_out), .cts_n(cts_n), .dsr_n(dsr_n),
  .rts_n(rts_n), .dtr_n(dtr_n), .rx_data_ready(rx_data_ready),
  .tx_holding_empty(tx_holding_empty), .irq_out(irq_out));

// file: dv/modem_model.sv
/*
  behavioural modem: sends and receives frames, drives handshake lines.
  assumes 16-clock bits (baud select 0) and calls made at a falling edge.
*/
`timescale 1ns/10ps
module modem_model (
  input wire logic ref_clk,
  input wire logic serial_out,
  output logic serial_in,
  output logic cts_n,
  output logic dsr_n
);
  int per = 16;
  initial begin
    serial_in = 1'b1;
    cts_n = 1'b0;
    dsr_n = 1'b1;
  end
  // lsb first, one stop; line returns to its idle-high level between frames
  task automatic send(input logic [7:0] d, input int n);
    serial_in = 1'b0;
    repeat (per) @(negedge ref_clk);
    for (int i = 0; i < n; i++) begin
      serial_in = d[i];
      repeat (per) @(negedge ref_clk);
    end
    serial_in = 1'b1;
    repeat (per) @(negedge ref_clk);
  endtask
  task automatic recv(output logic [7:0] d, input int n, output bit ok);
    int t;
    d = 8'h00;
    t = 0;
    while (serial_out !== 1'b0 && t < 4000) begin
      @(negedge ref_clk);
      t++;
    end
    repeat (per / 2) @(negedge ref_clk);
    for (int i = 0; i < n; i++) begin
      repeat (per) @(negedge ref_clk);
      d[i] = serial_out;
    end
    repeat (per) @(negedge ref_clk);
    ok = (serial_out === 1'b1) && (t < 4000);
  endtask
endmodule // modem_model

// file: dv/test_uart_buffers_and_interrupts.sv
/*
  self-checking bench for the serial transceiver, queue-based model.
  assumes the modem model on the serial side and the checker bound in.
*/
`timescale 1ns/10ps
module test_uart_buffers_and_interrupts;
  logic ref_clk, srst, cs_n, rd_n, wr_n, data_oe, serial_in, serial_out;
  logic cts_n, dsr_n, rts_n, dtr_n, rx_data_ready, tx_holding_empty, irq_out;
  logic [2:0] addr;
  logic [7:0] data_in, data_out;
  logic [7:0] rxq[$];
  logic [7:0] txq[$];
  int error_cnt = 0;
  int total_checks = 0;
  uart_buffers_and_interrupts u_dut (
    .ref_clk(ref_clk), .srst(srst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .serial_in(serial_in), .serial_out(serial_out), .cts_n(cts_n), .dsr_n(dsr_n),
    .rts_n(rts_n), .dtr_n(dtr_n), .rx_data_ready(rx_data_ready),
    .tx_holding_empty(tx_holding_empty), .irq_out(irq_out));
  modem_model u_modem (.ref_clk(ref_clk), .serial_out(serial_out),
    .serial_in(serial_in), .cts_n(cts_n), .dsr_n(dsr_n));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // strobes held two cycles; the next call's first wait gives the idle cycle
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    addr = a;
    data_in = d;
    cs_n = 1'b0;
    wr_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    cs_n = 1'b1;
    wr_n = 1'b1;
  endtask
  task automatic rd(input logic [2:0] a, input int h, output logic [7:0] d);
    @(negedge ref_clk);
    addr = a;
    cs_n = 1'b0;
    rd_n = 1'b0;
    repeat (h) @(negedge ref_clk);
    d = data_out;
    cs_n = 1'b1;
    rd_n = 1'b1;
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] exp, input string what);
    logic [7:0] v;
    rd(a, 2, v);
    chk(what, v, exp);
  endtask
  // long status read with a modem line edge in its middle
  task automatic slow_rd(input logic [7:0] exp, input logic lvl);
    logic [7:0] v;
    fork
      rd(uart_pkg::ADDR_STATUS, 6, v);
      begin
        repeat (3) @(negedge ref_clk);
        u_modem.dsr_n = lvl;
      end
    join
    chk("slow read", v, exp);
  endtask
  task automatic wait_rx();
    int t;
    t = 0;
    while (rx_data_ready !== 1'b1 && t < 400) begin
      @(negedge ref_clk);
      t++;
    end
  endtask
  initial begin
    #2000000;
    error_cnt++;
    final_report();
  end
  initial begin : main
    logic [7:0] v, d, e, m;
    bit ok;
    int n;
    srst = 1'b1;
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 3'h0;
    data_in = 8'h00;
    void'($urandom(66));
    repeat (12) @(negedge ref_clk);
    srst = 1'b0;
    rdc(uart_pkg::ADDR_MODEM_CTRL, 8'h10, "mcr");
    wr(uart_pkg::ADDR_MODEM_CTRL, 8'h13);
    chk("rts dtr on", {6'h00, rts_n, dtr_n}, 8'h00);
    rdc(3'h7, 8'h00, "spare");
    wr(uart_pkg::ADDR_MODEM_CTRL, 8'h14);
    chk("rts dtr off", {6'h00, rts_n, dtr_n}, 8'h03);
    chk("irq tc", irq_out, 1'b1);
    rdc(uart_pkg::ADDR_STATUS, 8'h60, "status");
    chk("irq clr", irq_out, 1'b0);
    wr(uart_pkg::ADDR_STATUS, 8'hff);
    rdc(uart_pkg::ADDR_STATUS, 8'h00, "status clr");
    chk("empty pin", tx_holding_empty, 1'b1);
    wr(uart_pkg::ADDR_MODEM_CTRL, 8'h1c);
    u_modem.dsr_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk("irq modem", irq_out, 1'b1);
    rdc(uart_pkg::ADDR_MODEM_STAT, 8'h03, "msr");
    chk("irq msr", irq_out, 1'b0);
    rdc(uart_pkg::ADDR_STATUS, 8'h10, "modem flag");
    wr(uart_pkg::ADDR_MODEM_CTRL, 8'h14);
    u_modem.dsr_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk("irq masked", irq_out, 1'b0);
    rdc(uart_pkg::ADDR_MODEM_STAT, 8'h01, "msr live");
    slow_rd(8'h10, 1'b0);
    rdc(uart_pkg::ADDR_STATUS, 8'h00, "recur");
    slow_rd(8'h00, 1'b1);
    rdc(uart_pkg::ADDR_STATUS, 8'h10, "late set");
    for (n = 5; n <= 8; n++) begin
      d = 8'($urandom);
      rxq.push_back(d & 8'((16'h1 << n) - 16'h1));
      wr(uart_pkg::ADDR_CONFIG, 8'(n - 5));
      u_modem.send(d, n);
      wait_rx();
      chk("irq rx", irq_out, 1'b0);
      rdc(uart_pkg::ADDR_DATA, rxq.pop_front(), "rx data");
      chk("rx pin", rx_data_ready, 1'b0);
    end
    rdc(uart_pkg::ADDR_STATUS, 8'h80, "rx event");
    repeat (2) begin
      d = 8'($urandom);
      rxq.push_back(d);
      u_modem.send(d, 8);
    end
    chk("irq overrun", irq_out, 1'b1);
    rdc(uart_pkg::ADDR_STATUS, 8'h84, "overrun");
    repeat (2) begin
      wait_rx();
      rdc(uart_pkg::ADDR_DATA, rxq.pop_front(), "rx kept");
    end
    rd(uart_pkg::ADDR_STATUS, 2, v);
    for (n = 5; n <= 8; n += 3) begin
      m = 8'((16'h1 << n) - 16'h1);
      d = 8'($urandom);
      e = 8'($urandom);
      txq.push_back(d & m);
      txq.push_back(e & m);
      wr(uart_pkg::ADDR_CONFIG, 8'(n - 5));
      fork
        begin
          wr(uart_pkg::ADDR_DATA, d);
          wr(uart_pkg::ADDR_DATA, e);
          chk("tx held", tx_holding_empty, 1'b0);
        end
        repeat (2) begin
          u_modem.recv(v, n, ok);
          chk("tx data", v, txq.pop_front());
          chk("tx stop", ok, 1'b1);
        end
      join
      repeat (20) @(negedge ref_clk);
      chk("irq done", irq_out, 1'b1);
      wr(uart_pkg::ADDR_MODEM_CTRL, 8'h10);
      chk("irq gated", irq_out, 1'b0);
      wr(uart_pkg::ADDR_MODEM_CTRL, 8'h14);
      rdc(uart_pkg::ADDR_STATUS, 8'h60, "tx complete");
    end
    d = 8'($urandom);
    e = 8'($urandom);
    fork
      begin
        wr(uart_pkg::ADDR_DATA, d);
        wr(uart_pkg::ADDR_DATA, e);
      end
      begin
        repeat (40) @(negedge ref_clk);
        u_modem.cts_n = 1'b1;
      end
      u_modem.recv(v, 8, ok);
    join
    chk("cts first", v, d);
    repeat (100) @(negedge ref_clk);
    chk("cts hold", serial_out, 1'b1);
    u_modem.cts_n = 1'b0;
    u_modem.recv(v, 8, ok);
    chk("cts second", v, e);
    // five bits with even transmit parity: the sixth bit seen is parity
    wr(uart_pkg::ADDR_CONFIG, 8'h10);
    d = 8'($urandom);
    fork
      wr(uart_pkg::ADDR_DATA, d);
      u_modem.recv(v, 6, ok);
    join
    chk("tx parity", v, {2'h0, ^d[4:0], d[4:0]});
    chk("parity stop", ok, 1'b1);
    final_report();
  end
endmodule // test_uart_buffers_and_interrupts
